// >>> tb/counter_array_pwm8_tb.sv
// Self-checking testbench for the counter array eight-bit PWM block
`timescale 1ns/1ps
`default_nettype none
module counter_array_pwm8_tb;
    import counter_array_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Clock, reset and design inputs, all given a value at time zero
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic compare_low_wr = 1'b0;
    logic compare_high_wr = 1'b0;
    logic pwm_enable = 1'b0;
    logic match_flag_enable = 1'b0;
    logic [2:0] cycle_length_select = 3'h0;
    logic watchdog_enable = 1'b0;
    logic counter_run = 1'b0;
    logic count_tick = 1'b0;
    logic event_flag_clr = 1'b0;
    logic overflow_flag_clr = 1'b0;
    // Design outputs
    logic [7:0] sfr_rdata;
    logic comparator_enable;
    logic module_event_flag;
    logic cycle_overflow_flag;
    logic [7:0] compare_low;
    logic [7:0] compare_high;
    logic module_output_pin;
    // Bookkeeping
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    integer seed = 32'h317e75de;
    logic [15:0] exp_q[$];   // Expected read data, oldest first
    logic [7:0] hi_val;
    logic [7:0] c_val;
    logic [7:0] tbl[4];

    counter_array_pwm8 dut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .compare_low_wr(compare_low_wr), .compare_high_wr(compare_high_wr),
        .pwm_enable(pwm_enable), .match_flag_enable(match_flag_enable),
        .cycle_length_select(cycle_length_select),
        .watchdog_enable(watchdog_enable), .counter_run(counter_run),
        .count_tick(count_tick), .event_flag_clr(event_flag_clr),
        .overflow_flag_clr(overflow_flag_clr),
        .comparator_enable(comparator_enable),
        .module_event_flag(module_event_flag),
        .cycle_overflow_flag(cycle_overflow_flag),
        .compare_low(compare_low), .compare_high(compare_high),
        .module_output_pin(module_output_pin));

    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // Cycle ceiling: the full sequence needs roughly 12000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and drivers; all stimulus moves at falling edges
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One read; the expected value waits in the queue for the monitor
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        exp_q.push_back({8'h00, exp});
        @(negedge ref_clk);
        sfr_rd = 1'b0;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask

    // Compare strobe; high selects the staged byte
    task automatic cmp(logic high, logic [7:0] d);
        @(negedge ref_clk);
        sfr_wdata = d;
        compare_low_wr = ~high;
        compare_high_wr = high;
        @(negedge ref_clk);
        compare_low_wr = 1'b0;
        compare_high_wr = 1'b0;
    endtask

    // Settle two periods, clear flags, then count high cycles over one
    // period; any alignment works because the wave repeats every 256
    task automatic duty(logic [15:0] exp_hi, logic exp_ev);
        logic [15:0] n;
        n = 16'h0000;
        repeat (600) @(negedge ref_clk);
        event_flag_clr = 1'b1;
        overflow_flag_clr = 1'b1;
        @(negedge ref_clk);
        event_flag_clr = 1'b0;
        overflow_flag_clr = 1'b0;
        repeat (PWM_PERIOD_TICKS) begin
            @(negedge ref_clk);
            n = n + {15'h0000, module_output_pin};
        end
        check("high_cycles", n, exp_hi);
        check("overflow_flag", {15'h0, cycle_overflow_flag}, 16'h1);
        check("event", {15'h0, module_event_flag}, {15'h0, exp_ev});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Monitor: a read taken at a rising edge shows data by the next fall
    initial begin
        logic pend;
        logic [15:0] e;
        forever begin
            @(posedge ref_clk);
            pend = sfr_rd;
            @(negedge ref_clk);
            if (pend) begin
                e = exp_q.pop_front();
                check("read_data", {8'h00, sfr_rdata}, e);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        // Reset values of both counter bytes
        rd(COUNTER_LOW_OFS, COUNTER_BYTE_RST);
        rd(COUNTER_HIGH_OFS, COUNTER_BYTE_RST);
        // Load the counter just below a carry, then try a locked write
        hi_val = 8'($random(seed)) & 8'hfe;
        wr(COUNTER_LOW_OFS, LOW_BYTE_TOP);
        wr(COUNTER_HIGH_OFS, hi_val);
        rd(COUNTER_LOW_OFS, LOW_BYTE_TOP);
        rd(COUNTER_HIGH_OFS, hi_val);
        watchdog_enable = 1'b1;
        wr(COUNTER_LOW_OFS, 8'h5a);
        wr(COUNTER_HIGH_OFS, 8'ha5);
        rd(COUNTER_LOW_OFS, LOW_BYTE_TOP);
        rd(COUNTER_HIGH_OFS, hi_val);
        // One tick carries; the snapshot stays stale until a low read
        counter_run = 1'b1;
        count_tick = 1'b1;
        @(negedge ref_clk);
        count_tick = 1'b0;
        rd(COUNTER_HIGH_OFS, hi_val);
        rd(COUNTER_LOW_OFS, LOW_BYTE_BOTTOM);
        rd(COUNTER_HIGH_OFS, hi_val + 8'h01);
        // PWM with both duty extremes and two random high times
        count_tick = 1'b1;
        pwm_enable = 1'b1;
        match_flag_enable = 1'b1;
        tbl = '{8'h00, 8'hff, 8'($random(seed)), 8'($random(seed))};
        foreach (tbl[i]) begin
            c_val = tbl[i];
            // Low byte first, then high, as software must
            cmp(1'b0, 8'($random(seed)));
            check("en_low", {15'h0, comparator_enable}, 16'h0);
            cmp(1'b1, c_val);
            check("en_high", {15'h0, comparator_enable}, 16'h1);
            check("staged", {8'h00, compare_high}, {8'h00, c_val});
            duty(16'h0100 - {8'h00, c_val}, 1'b1);
            check("reloaded", {8'h00, compare_low}, {8'h00, c_val});
        end
        // Match flag disabled: duty unchanged, no event
        match_flag_enable = 1'b0;
        duty(16'h0100 - {8'h00, c_val}, 1'b0);
        // Every other cycle length select leaves the pin low
        match_flag_enable = 1'b1;
        for (int m = 1; m < 8; m++) begin
            cycle_length_select = 3'(m);
            duty(16'h0000, 1'b0);
        end
        cycle_length_select = CYCLE_LENGTH_SELECT_8BIT;
        pwm_enable = 1'b0;
        duty(16'h0000, 1'b0);
        // A lone low compare write disables the comparator: zero duty
        pwm_enable = 1'b1;
        cmp(1'b0, 8'h40);
        duty(16'h0000, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire

// >>> verilog/counter_array_count16.sv
// Sixteen-bit counter of the counter array with byte loads
`timescale 1ns/1ps
`default_nettype none
module counter_array_count16 #(
    parameter int WIDTH = counter_array_pkg::COUNTER_WIDTH
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic step,
    input wire logic load_low,
    input wire logic load_high,
    input wire logic [7:0] load_data,
    // Count value
    output logic [WIDTH-1:0] count_reg
);
    import counter_array_pkg::*;

    // Next count: software loads take priority over the tick
    logic [WIDTH-1:0] count_next;
    assign count_next = load_low ? {count_reg[WIDTH-1:8], load_data} :
                        load_high ? {load_data, count_reg[7:0]} :
                        step ? count_reg + 1'b1 : count_reg;

    ////////////////////////////////////////////////////////////////////////
    // Counter register; low byte carries into the high byte
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (ce) begin
            count_reg <= count_next;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/counter_array_pkg.sv
// Constants shared by the counter array eight-bit PWM block
package counter_array_pkg;
    // Register offsets on the special function register port
    localparam logic [7:0] COUNTER_LOW_OFS = 8'hf9;
    localparam logic [7:0] COUNTER_HIGH_OFS = 8'hfa;
    // Values after reset
    localparam logic [7:0] COUNTER_BYTE_RST = 8'h00;
    localparam logic [7:0] COMPARE_RST = 8'h00;
    localparam logic [7:0] READ_DATA_RST = 8'h00;
    // Cycle length select code for eight-bit PWM
    localparam logic [2:0] CYCLE_LENGTH_SELECT_8BIT = 3'h0;
    // Low byte limits: wrap happens on the step from top to bottom
    localparam logic [7:0] LOW_BYTE_TOP = 8'hff;
    localparam logic [7:0] LOW_BYTE_BOTTOM = 8'h00;
    // Counter clock ticks in one PWM period
    localparam int PWM_PERIOD_TICKS = 256;
    // Counter width
    localparam int COUNTER_WIDTH = 16;
endpackage

// >>> verilog/counter_array_pwm8.sv
// One capture/compare module of the counter array in eight-bit PWM mode
// Operation
// - Output goes high on low byte compare match
// - Output goes low on low byte overflow unless compare high is zero
// - Wrap reloads compare low from compare high
// - PWM mode needs both enables, select 000b
// - Match sets event flag when match enabled
// - Each low byte overflow sets overflow flag
// - Low write clears, high write sets comparator
// - High fraction is (256 minus compare high)/256
// - Comparator disabled gives zero percent duty
// - Watchdog enable blocks counter byte writes
// - High byte read returns low-read snapshot
// - Counter sixteen bits, low and high bytes
`timescale 1ns/1ps
`default_nettype none
module counter_array_pwm8 (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Compare register write strobes, data on sfr_wdata
    input wire logic compare_low_wr,
    input wire logic compare_high_wr,
    // Loose configuration bits
    input wire logic pwm_enable,
    input wire logic match_flag_enable,
    input wire logic [2:0] cycle_length_select,
    input wire logic watchdog_enable,
    input wire logic counter_run,
    input wire logic count_tick,
    // Flag clears, one-cycle pulses
    input wire logic event_flag_clr,
    input wire logic overflow_flag_clr,
    // Status and pin
    output logic comparator_enable,
    output logic module_event_flag,
    output logic cycle_overflow_flag,
    output logic [7:0] compare_low,
    output logic [7:0] compare_high,
    output logic module_output_pin
);
    import counter_array_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [COUNTER_WIDTH-1:0] count_reg; // Live counter
    logic [7:0] compare_low_reg; // Active compare value
    logic [7:0] compare_high_reg; // Staged compare value
    logic comparator_enable_reg; // Comparator enable
    logic event_flag_reg; // Sticky match flag
    logic overflow_flag_reg; // Sticky overflow flag
    logic [7:0] snapshot_reg; // High byte as seen at last low read
    logic [7:0] rdata_reg; // Registered read data
    logic pin_reg; // Output pin

    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire [7:0] low_byte = count_reg[7:0];
    wire [7:0] high_byte = count_reg[15:8];
    wire sel_low = (sfr_addr == COUNTER_LOW_OFS);
    wire sel_high = (sfr_addr == COUNTER_HIGH_OFS);
    // Writes are dropped while the watchdog owns the counter
    wire load_low = sfr_wr & sel_low & ~watchdog_enable;
    wire load_high = sfr_wr & sel_high & ~watchdog_enable;
    // A software load replaces the tick in that cycle
    wire step = counter_run & count_tick & ~load_low & ~load_high;
    wire wrap = step & (low_byte == LOW_BYTE_TOP);
    wire [7:0] low_after = low_byte + 8'h01;
    // Mode entry
    wire pwm8_active = comparator_enable_reg & pwm_enable &
                       (cycle_length_select == CYCLE_LENGTH_SELECT_8BIT);
    // On the wrap the comparison uses the value being reloaded, so a
    // compare high of zero keeps the pin high for the whole period
    wire [7:0] compare_eff = wrap ? compare_high_reg : compare_low_reg;
    wire match_hit = pwm8_active & step & (low_after == compare_eff);

    ////////////////////////////////////////////////////////////////////////
    // Counter
    counter_array_count16 #(
        .WIDTH(COUNTER_WIDTH)
    ) u_count (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .step(step),
        .load_low(load_low),
        .load_high(load_high),
        .load_data(sfr_wdata),
        .count_reg(count_reg)
    );

    ////////////////////////////////////////////////////////////////////////
    // Compare registers and comparator enable; software writes win over
    // the reload, and the low-then-high order leaves the enable set
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            compare_low_reg <= COMPARE_RST;
            compare_high_reg <= COMPARE_RST;
            comparator_enable_reg <= 1'b0;
        end else if (ce) begin
            if (compare_low_wr) begin
                compare_low_reg <= sfr_wdata;
                comparator_enable_reg <= 1'b0;
            end else if (wrap) begin
                compare_low_reg <= compare_high_reg;
            end
            if (compare_high_wr) begin
                compare_high_reg <= sfr_wdata;
                comparator_enable_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output pin: match raises, overflow lowers, disabled holds low
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_reg <= 1'b0;
        end else if (ce) begin
            if (!pwm8_active) begin
                pin_reg <= 1'b0;
            end else if (match_hit) begin
                pin_reg <= 1'b1;
            end else if (wrap) begin
                pin_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags; a set in the clear cycle wins so no event is lost
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            event_flag_reg <= 1'b0;
            overflow_flag_reg <= 1'b0;
        end else if (ce) begin
            if (match_hit & match_flag_enable) begin
                event_flag_reg <= 1'b1;
            end else if (event_flag_clr) begin
                event_flag_reg <= 1'b0;
            end
            if (wrap) begin
                overflow_flag_reg <= 1'b1;
            end else if (overflow_flag_clr) begin
                overflow_flag_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Snapshot and read data; high reads never see a torn count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            snapshot_reg <= COUNTER_BYTE_RST;
            rdata_reg <= READ_DATA_RST;
        end else if (ce) begin
            if (sfr_rd & sel_low) begin
                snapshot_reg <= high_byte;
            end
            if (sfr_rd) begin
                // Unmapped addresses read as zero
                rdata_reg <= sel_low ? low_byte :
                             sel_high ? snapshot_reg : READ_DATA_RST;
            end
        end
    end

    // Outputs, all from flip-flops
    assign sfr_rdata = rdata_reg;
    assign comparator_enable = comparator_enable_reg;
    assign module_event_flag = event_flag_reg;
    assign cycle_overflow_flag = overflow_flag_reg;
    assign compare_low = compare_low_reg;
    assign compare_high = compare_high_reg;
    assign module_output_pin = pin_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_wrap;
        ce && wrap;
    endsequence

    property p_set_on_match;
        @(posedge ref_clk) disable iff (rst)
        ce && match_hit |=> module_output_pin;
    endproperty
    a_set_on_match: assert property (p_set_on_match)
        else $error("pin not high after match");

    property p_clear_on_overflow;
        @(posedge ref_clk) disable iff (rst)
        s_wrap and (compare_high_reg != 8'h00) |=> !module_output_pin;
    endproperty
    a_clear_on_overflow: assert property (p_clear_on_overflow)
        else $error("pin not low after overflow");

    property p_reload;
        @(posedge ref_clk) disable iff (rst)
        s_wrap and !compare_low_wr |=> compare_low == $past(compare_high);
    endproperty
    a_reload: assert property (p_reload)
        else $error("compare low not reloaded on wrap");

    property p_zero_duty;
        @(posedge ref_clk) disable iff (rst)
        ce && !comparator_enable |=> !module_output_pin;
    endproperty
    a_zero_duty: assert property (p_zero_duty)
        else $error("pin high while comparator disabled");

    property p_event_flag;
        @(posedge ref_clk) disable iff (rst)
        ce && match_hit && match_flag_enable |=> module_event_flag;
    endproperty
    a_event_flag: assert property (p_event_flag)
        else $error("event flag missed");

    property p_overflow_flag;
        @(posedge ref_clk) disable iff (rst)
        s_wrap |=> cycle_overflow_flag && count_reg[7:0] == 8'h00;
    endproperty
    a_overflow_flag: assert property (p_overflow_flag)
        else $error("overflow flag missed");

    property p_compare_writes;
        @(posedge ref_clk) disable iff (rst)
        ce && (compare_low_wr || compare_high_wr) |=>
            comparator_enable == $past(compare_high_wr);
    endproperty
    a_compare_writes: assert property (p_compare_writes)
        else $error("comparator enable wrong after write");

    property p_watchdog_lock;
        @(posedge ref_clk) disable iff (rst)
        ce && sfr_wr && sel_low && watchdog_enable && !step |=>
            $stable(count_reg);
    endproperty
    a_watchdog_lock: assert property (p_watchdog_lock)
        else $error("counter written under watchdog");

    property p_snapshot;
        @(posedge ref_clk) disable iff (rst)
        ce && sfr_rd && sel_low |=> snapshot_reg == $past(high_byte);
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("snapshot not taken");

    property p_count_step;
        @(posedge ref_clk) disable iff (rst)
        ce && step |=> count_reg == $past(count_reg) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not advance");
endmodule
`default_nettype wire
